// file: hsb_commutation.sv
// Purpose: Hall-sensored six-step commutation with PWM, dead time and faults
// Assumes: Hall and comparator inputs are asynchronous; bus voltage code is synchronous
// Notes:   Register map over Avalon-MM, one answer cycle per access
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`default_nettype none
`timescale 1ns/1ps
`include "hsb_defines.svh"

module hsb_commutation #(
  parameter int PWM_PERIOD_CYC = `HSB_CLK_HZ / `HSB_PWM_HZ
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire hsb_pkg::hsb_avs_req_t avsReq,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic [2:0] hallIn,
  input wire logic fastCurrentComparator,
  input wire logic [15:0] busVoltage,
  output hsb_pkg::hsb_bridge_t bridge,
  output logic [2:0] hallEvent,
  output logic loopTrig,
  output logic [15:0] currentRef,
  output logic faultFlag
);
  import hsb_pkg::*;

  // ****************************************
  // Derived timing
  // ****************************************
  // Least time: round the dead time up to whole cycles
  localparam int DEAD_CYC = (`HSB_DEAD_NS + `HSB_CLK_NS - 1) / `HSB_CLK_NS;
  localparam int LOOP_DIV = `HSB_PWM_HZ / `HSB_LOOP_HZ;
  localparam logic [15:0] PERIOD_LAST = 16'(PWM_PERIOD_CYC - 1);
  localparam logic [7:0] DEAD_LAST = 8'(DEAD_CYC - 1);
  localparam logic [4:0] LOOP_LAST = 5'(LOOP_DIV - 1);
  localparam logic [7:0] TCNT_STEP = 8'(`HSB_TCNT_MHZ);
  localparam logic [7:0] TCNT_MOD = 8'(`HSB_CLK_MHZ);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] hallMeta_r; // First stage, read only by second
  logic [2:0] hallS_r; // Clean Hall levels
  logic ocMeta_r; // First stage of comparator
  logic ocS_r; // Clean comparator level

  // Two flops per asynchronous pin
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hallMeta_r <= 3'h0;
      hallS_r <= 3'h0;
      ocMeta_r <= 1'b0;
      ocS_r <= 1'b0;
    end else begin
      hallMeta_r <= hallIn;
      hallS_r <= hallMeta_r;
      ocMeta_r <= fastCurrentComparator;
      ocS_r <= ocMeta_r;
    end
  end

  // ****************************************
  // Registers and bus decode
  // ****************************************
  logic [4:0] ctrl_r; // Run, direction, mode
  logic [15:0] dutyReg_r; // Software duty, compare count
  logic [15:0] ovLim_r; // Overvoltage threshold
  logic [15:0] uvLim_r; // Undervoltage threshold
  logic ocFault_r; // Sticky overcurrent
  logic hallFault_r; // Sticky invalid Hall pattern
  logic ovFault_r; // Sticky overvoltage
  logic uvFault_r; // Sticky undervoltage
  logic outEn_r; // Bridge enabled, changes at boundaries
  logic [31:0] timeCnt_r; // Free-running 96 MHz count
  logic [31:0] commTime_r; // Count at last commutation
  logic [31:0] rdMux; // Read data selection
  logic [31:0] statusWord; // Status register image

  wire logic accept = (avsReq.read | avsReq.write) & avsWaitrequest; // Request not yet answered
  wire logic wrDone = avsReq.write & ~avsWaitrequest; // Write takes effect here
  wire logic selCtrl = avsReq.address == `HSB_OFS_CTRL;
  wire logic selDuty = avsReq.address == `HSB_OFS_DUTY;
  wire logic selStatus = avsReq.address == `HSB_OFS_STATUS;
  wire logic selCurLim = avsReq.address == `HSB_OFS_CUR_LIMIT;
  wire logic selOv = avsReq.address == `HSB_OFS_OV_LIMIT;
  wire logic selUv = avsReq.address == `HSB_OFS_UV_LIMIT;
  wire logic [31:0] clrMask = (wrDone & selStatus) ? avsReq.writedata : 32'h0000_0000;
  wire logic runEn = ctrl_r[`HSB_CTRL_RUN];
  wire logic dirCw = ctrl_r[`HSB_CTRL_DIR];
  wire logic [2:0] modeBits = ctrl_r[`HSB_CTRL_MODE_HI:`HSB_CTRL_MODE_LO];

  assign statusWord = {23'h0, outEn_r, uvFault_r, ovFault_r, hallFault_r, ocFault_r, 1'b0, hallS_r};

  // Address decode; unmapped reads return zero
  always_comb begin
    if (avsReq.address == `HSB_OFS_CTRL) begin
      rdMux = {27'h0, ctrl_r};
    end else if (avsReq.address == `HSB_OFS_DUTY) begin
      rdMux = {16'h0, dutyReg_r};
    end else if (avsReq.address == `HSB_OFS_STATUS) begin
      rdMux = statusWord;
    end else if (avsReq.address == `HSB_OFS_COMM_TIME) begin
      rdMux = commTime_r;
    end else if (avsReq.address == `HSB_OFS_CUR_LIMIT) begin
      rdMux = {16'h0, currentRef};
    end else if (avsReq.address == `HSB_OFS_OV_LIMIT) begin
      rdMux = {16'h0, ovLim_r};
    end else if (avsReq.address == `HSB_OFS_UV_LIMIT) begin
      rdMux = {16'h0, uvLim_r};
    end else if (avsReq.address == `HSB_OFS_TIME_NOW) begin
      rdMux = timeCnt_r;
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  // Waitrequest drops for exactly one cycle per access
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h0000_0000;
    end else begin
      avsWaitrequest <= ~accept;
      if (accept) begin
        avsReaddata <= rdMux;
      end
    end
  end

  // Writable registers; duty is held until software rewrites it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `HSB_CTRL_RST;
      dutyReg_r <= `HSB_DUTY_RST;
      currentRef <= `HSB_CUR_LIMIT_RST;
      ovLim_r <= `HSB_OV_LIMIT_RST;
      uvLim_r <= `HSB_UV_LIMIT_RST;
    end else if (wrDone) begin
      if (selCtrl) begin
        ctrl_r <= avsReq.writedata[4:0];
      end
      if (selDuty) begin
        dutyReg_r <= avsReq.writedata[15:0];
      end
      if (selCurLim) begin
        currentRef <= avsReq.writedata[15:0];
      end
      if (selOv) begin
        ovLim_r <= avsReq.writedata[15:0];
      end
      if (selUv) begin
        uvLim_r <= avsReq.writedata[15:0];
      end
    end
  end

  // ****************************************
  // Hall decode, events, time capture
  // ****************************************
  logic [2:0] hallPrev_r; // Levels one cycle ago
  logic [2:0] sector_r; // Current sector code
  logic [7:0] tAcc_r; // Fractional 96/200 accumulator
  wire logic [2:0] hallEdge = hallS_r ^ hallPrev_r; // Both polarities per phase
  wire logic hallBad = (hallS_r == `HSB_HALL_ZERO) | (hallS_r == `HSB_HALL_ONES);
  wire logic commute = |hallEdge;
  wire logic [8:0] tSum = {1'b0, tAcc_r} + {1'b0, TCNT_STEP};
  wire logic tTick = tSum >= {1'b0, TCNT_MOD};

  // Time counter steps at 96 MHz on average, enable from accumulator
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tAcc_r <= 8'h00;
      timeCnt_r <= 32'h0000_0000;
    end else begin
      tAcc_r <= tTick ? 8'(tSum - {1'b0, TCNT_MOD}) : tSum[7:0];
      if (tTick) begin
        timeCnt_r <= timeCnt_r + 32'h0000_0001;
      end
    end
  end

  // Sector follows every Hall edge; capture the commutation time
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hallPrev_r <= 3'h0;
      sector_r <= 3'h0;
      hallEvent <= 3'h0;
      commTime_r <= 32'h0000_0000;
    end else begin
      hallPrev_r <= hallS_r;
      hallEvent <= hallEdge;
      if (commute) begin
        sector_r <= hallS_r;
        commTime_r <= timeCnt_r;
      end
    end
  end

  // ****************************************
  // Vector selection
  // ****************************************
  // Vector n: high phase, low phase. V1 A-B, V2 A-C, V3 B-C, V4 B-A, V5 C-A, V6 C-B
  logic [2:0] vecCcw; // Vector for counterclockwise
  logic [2:0] vecSel; // Vector actually applied
  logic [1:0] hiPh; // Phase switched to the positive rail
  logic [1:0] loPh; // Phase switched to the negative rail
  logic [1:0] prevHi_r; // High phase before last commutation
  logic [1:0] prevLo_r; // Low phase before last commutation

  // Sector to counterclockwise vector; invalid codes never reach the bridge
  always_comb begin
    case (sector_r)
      3'h4: vecCcw = 3'h2;
      3'h6: vecCcw = 3'h3;
      3'h2: vecCcw = 3'h4;
      3'h3: vecCcw = 3'h5;
      3'h1: vecCcw = 3'h6;
      default: vecCcw = 3'h1;
    endcase
  end

  // Clockwise uses the opposite vector; start needs no alignment
  assign vecSel = dirCw ? ((vecCcw > 3'h3) ? vecCcw - 3'h3 : vecCcw + 3'h3) : vecCcw;

  // Two distinct conducting phases per vector
  always_comb begin
    case (vecSel)
      3'h1: begin hiPh = 2'd0; loPh = 2'd1; end
      3'h2: begin hiPh = 2'd0; loPh = 2'd2; end
      3'h3: begin hiPh = 2'd1; loPh = 2'd2; end
      3'h4: begin hiPh = 2'd1; loPh = 2'd0; end
      3'h5: begin hiPh = 2'd2; loPh = 2'd0; end
      default: begin hiPh = 2'd2; loPh = 2'd1; end
    endcase
  end

  // Remember the previous pair so chop-then-on can tell a fresh leg
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prevHi_r <= 2'd0;
      prevLo_r <= 2'd0;
    end else if (commute) begin
      prevHi_r <= hiPh;
      prevLo_r <= loPh;
    end
  end

  // ****************************************
  // Chop selection
  // ****************************************
  logic chopHi; // High leg modulated
  logic chopLo; // Low leg modulated
  wire hsb_mode_t mode = (modeBits > 3'(HSB_MODE_ON_PWM)) ? HSB_MODE_DOUBLE : hsb_mode_t'(modeBits);

  // Single-chop variants hold one leg steady
  always_comb begin
    case (mode)
      HSB_MODE_HPWM_LON: begin chopHi = 1'b1; chopLo = 1'b0; end
      HSB_MODE_HON_LPWM: begin chopHi = 1'b0; chopLo = 1'b1; end
      HSB_MODE_PWM_ON: begin chopHi = hiPh != prevHi_r; chopLo = loPh != prevLo_r; end
      HSB_MODE_ON_PWM: begin chopHi = hiPh == prevHi_r; chopLo = loPh == prevLo_r; end
      default: begin chopHi = 1'b1; chopLo = 1'b1; end
    endcase
  end

  // ****************************************
  // PWM channels and strobes
  // ****************************************
  logic [15:0] cnt_r [3]; // Per-channel counters
  logic [15:0] dutyAct_r; // Duty in force this cycle
  logic [4:0] loopDiv_r; // Reload strobes per loop trigger
  wire logic reloadStb = cnt_r[0] == PERIOD_LAST; // Channel 0 drives all channels
  wire logic kill = hallBad | ocS_r | ocFault_r | hallFault_r | ovFault_r | uvFault_r | ~outEn_r;

  // Channels 1 and 2 restart on channel 0's strobe, not their own
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r[0] <= 16'h0000;
      cnt_r[1] <= 16'h0000;
      cnt_r[2] <= 16'h0000;
    end else begin
      for (int c = 0; c < 3; c++) begin
        cnt_r[c] <= reloadStb ? 16'h0000 : cnt_r[c] + 16'h0001;
      end
    end
  end

  // Duty, enable and loop divider change only at a cycle boundary
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dutyAct_r <= `HSB_DUTY_RST;
      outEn_r <= 1'b0;
      loopDiv_r <= 5'h00;
      loopTrig <= 1'b0;
    end else begin
      loopTrig <= reloadStb && loopDiv_r == LOOP_LAST;
      if (reloadStb) begin
        dutyAct_r <= dutyReg_r;
        outEn_r <= runEn & ~(ocFault_r | hallFault_r | ovFault_r | uvFault_r);
        loopDiv_r <= (loopDiv_r == LOOP_LAST) ? 5'h00 : loopDiv_r + 5'h01;
      end
    end
  end

  // ****************************************
  // Faults
  // ****************************************
  wire logic ovNow = loopTrig & (busVoltage > ovLim_r);
  wire logic uvNow = loopTrig & (busVoltage < uvLim_r);

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ocFault_r <= 1'b0;
      hallFault_r <= 1'b0;
      ovFault_r <= 1'b0;
      uvFault_r <= 1'b0;
      faultFlag <= 1'b0;
    end else begin
      ocFault_r <= ocS_r | (ocFault_r & ~clrMask[`HSB_ST_OC]);
      hallFault_r <= hallBad | (hallFault_r & ~clrMask[`HSB_ST_HALLF]);
      ovFault_r <= ovNow | (ovFault_r & ~clrMask[`HSB_ST_OV]);
      uvFault_r <= uvNow | (uvFault_r & ~clrMask[`HSB_ST_UV]);
      faultFlag <= ocS_r | hallBad | ocFault_r | hallFault_r | ovFault_r | uvFault_r;
    end
  end

  // ****************************************
  // Gate drive with dead time
  // ****************************************
  logic [7:0] dead_r [3]; // Cycles both switches have been off
  logic [2:0] hiReq; // Wanted high switch state
  logic [2:0] loReq; // Wanted low switch state

  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      wire logic pwmRaw = cnt_r[p] < dutyAct_r; // Edge-aligned, active high
      wire logic isHi = hiPh == 2'(p);
      wire logic isLo = loPh == 2'(p);
      assign hiReq[p] = isHi ? (chopHi ? pwmRaw : 1'b1) : (isLo & chopLo & ~pwmRaw);
      assign loReq[p] = isLo ? (chopLo ? pwmRaw : 1'b1) : (isHi & chopHi & ~pwmRaw);

      // Any change passes through both-off for the dead time
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          bridge.hi[p] <= 1'b0;
          bridge.lo[p] <= 1'b0;
          dead_r[p] <= 8'h00;
        end else if (kill) begin
          bridge.hi[p] <= 1'b0;
          bridge.lo[p] <= 1'b0;
          dead_r[p] <= 8'h00;
        end else if ((bridge.hi[p] | bridge.lo[p]) && {hiReq[p], loReq[p]} != {bridge.hi[p], bridge.lo[p]}) begin
          bridge.hi[p] <= 1'b0;
          bridge.lo[p] <= 1'b0;
          dead_r[p] <= 8'h00;
        end else if (!(bridge.hi[p] | bridge.lo[p])) begin
          if (dead_r[p] >= DEAD_LAST) begin
            bridge.hi[p] <= hiReq[p];
            bridge.lo[p] <= loReq[p];
          end else begin
            dead_r[p] <= dead_r[p] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Assertions
  // ****************************************
  logic [7:0] hiOffCnt_r; // Cycles phase A high switch has been off

  // Helper for the dead-time check
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hiOffCnt_r <= 8'h00;
    end else if (bridge.hi[0]) begin
      hiOffCnt_r <= 8'h00;
    end else if (hiOffCnt_r != 8'hFF) begin
      hiOffCnt_r <= hiOffCnt_r + 8'h01;
    end
  end

  property p_hall_fault_off;
    @(posedge core_clk) disable iff (reset) hallBad |=> (bridge.hi == 3'h0 && bridge.lo == 3'h0) ##1 faultFlag;
  endproperty
  a_hall_fault_off: assert property (p_hall_fault_off) else $error("bridge on after bad Hall code");

  property p_two_phases;
    @(posedge core_clk) disable iff (reset) $countones(bridge.hi | bridge.lo) <= 2;
  endproperty
  a_two_phases: assert property (p_two_phases) else $error("more than two phases driven");

  property p_vector_100;
    @(posedge core_clk) disable iff (reset) (sector_r == 3'h4) |-> (dirCw ? (hiPh == 2'd2 && loPh == 2'd0) : (hiPh == 2'd0 && loPh == 2'd2));
  endproperty
  a_vector_100: assert property (p_vector_100) else $error("wrong vector for sector 100");

  property p_edge_event;
    @(posedge core_clk) disable iff (reset) (hallS_r[1] != $past(hallS_r[1])) |=> hallEvent[1] ##1 (sector_r == $past(hallS_r, 2));
  endproperty
  a_edge_event: assert property (p_edge_event) else $error("Hall edge without event");

  property p_capture;
    @(posedge core_clk) disable iff (reset) commute |=> (commTime_r == $past(timeCnt_r));
  endproperty
  a_capture: assert property (p_capture) else $error("commutation time not captured");

  property p_channel_sync;
    @(posedge core_clk) disable iff (reset) reloadStb |=> (cnt_r[1] == 16'h0000 && cnt_r[2] == 16'h0000 && cnt_r[0] == 16'h0000);
  endproperty
  a_channel_sync: assert property (p_channel_sync) else $error("channels out of step");

  property p_duty_hold;
    @(posedge core_clk) disable iff (reset) !reloadStb |=> $stable(dutyAct_r) && $stable(outEn_r);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed inside a cycle");

  property p_oc_off;
    @(posedge core_clk) disable iff (reset) $rose(ocS_r) |=> (bridge.hi == 3'h0 && bridge.lo == 3'h0) [*2];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("bridge on during overcurrent");

  property p_dead_time;
    @(posedge core_clk) disable iff (reset) $rose(bridge.lo[0]) |-> hiOffCnt_r >= 8'(DEAD_CYC);
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("dead time too short");

  property p_loop_trig;
    @(posedge core_clk) disable iff (reset) loopTrig |=> !loopTrig [*8];
  endproperty
  a_loop_trig: assert property (p_loop_trig) else $error("loop trigger too frequent");

endmodule // hsb_commutation
`default_nettype wire

// file: hsb_defines.svh
// Purpose: Constants for the Hall six-step commutation block
// Assumes: 200 MHz core clock, byte-addressed Avalon-MM register bus
// Notes:   Types live in hsb_pkg; this header holds only macros
`ifndef HSB_DEFINES_SVH
`define HSB_DEFINES_SVH

// Clock and timing
`define HSB_CLK_HZ 200000000
`define HSB_CLK_MHZ 200
`define HSB_CLK_NS 5
`define HSB_PWM_HZ 20000
`define HSB_LOOP_HZ 1000
`define HSB_DEAD_NS 1000
`define HSB_TCNT_MHZ 96
`define HSB_MIN_RPM 300
`define HSB_MAX_RPM 2200

// Register byte offsets
`define HSB_OFS_CTRL 8'h00
`define HSB_OFS_DUTY 8'h04
`define HSB_OFS_STATUS 8'h08
`define HSB_OFS_COMM_TIME 8'h0C
`define HSB_OFS_CUR_LIMIT 8'h10
`define HSB_OFS_OV_LIMIT 8'h14
`define HSB_OFS_UV_LIMIT 8'h18
`define HSB_OFS_TIME_NOW 8'h1C

// Control fields
`define HSB_CTRL_RUN 0
`define HSB_CTRL_DIR 1
`define HSB_CTRL_MODE_LO 2
`define HSB_CTRL_MODE_HI 4

// Status fields
`define HSB_ST_HALL_LO 0
`define HSB_ST_HALL_HI 2
`define HSB_ST_OC 4
`define HSB_ST_HALLF 5
`define HSB_ST_OV 6
`define HSB_ST_UV 7
`define HSB_ST_OUTEN 8

// Reset values
`define HSB_CTRL_RST 5'h00
`define HSB_DUTY_RST 16'h0000
`define HSB_CUR_LIMIT_RST 16'h0FA0
`define HSB_OV_LIMIT_RST 16'hFFFF
`define HSB_UV_LIMIT_RST 16'h0000

// Hall patterns that cannot occur on a healthy motor
`define HSB_HALL_ZERO 3'h0
`define HSB_HALL_ONES 3'h7

`endif

// file: hsb_pkg.sv
// Purpose: Shared types for the Hall six-step commutation block
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Numeric constants are in hsb_defines.svh
`default_nettype none
package hsb_pkg;
  // Chop modes, double-chop first so it is the reset value
  typedef enum logic [2:0] {
    HSB_MODE_DOUBLE,
    HSB_MODE_HPWM_LON,
    HSB_MODE_HON_LPWM,
    HSB_MODE_PWM_ON,
    HSB_MODE_ON_PWM
  } hsb_mode_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } hsb_avs_req_t;

  // Six gate commands, index 0..2 = phase A..C
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } hsb_bridge_t;
endpackage
`default_nettype wire

// file: hsb_motor_model.sv
// Purpose: Hall sensors and current comparator standing around the commutation block
// Assumes: Bench picks the rotor sector and any fault to inject
// Notes: Hall code order per sector follows the ccw rotor sequence
`timescale 1ns/1ps
`default_nettype none
module hsb_motor_model (
  input wire logic core_clk,
  input wire logic [2:0] sector,
  input wire logic hallBad,
  input wire logic overCurrent,
  input wire hsb_pkg::hsb_bridge_t bridge,
  output logic [2:0] hallIn,
  output logic fastCurrentComparator
);
  import hsb_pkg::*;
  // Hall code of each sector, one magnet half-turn high per phase
  logic [2:0] hallCode;
  assign hallCode = (sector == 3'h0) ? 3'h4 : (sector == 3'h1) ? 3'h6 : (sector == 3'h2) ? 3'h2 :
    (sector == 3'h3) ? 3'h3 : (sector == 3'h4) ? 3'h1 : 3'h5;
  // A broken sensor shows all ones, which no sector can
  always_ff @(posedge core_clk) begin
    hallIn <= hallBad ? 3'h7 : hallCode;
    fastCurrentComparator <= overCurrent;
  end
endmodule // hsb_motor_model
`default_nettype wire

// file: hsb_commutation_test.sv
// Purpose: Self-checking bench for the commutation block
// Assumes: Short PWM period of 400 cycles, dead time 200 cycles
// Notes: Full duty keeps the conducting pair steadily on for easy checks
`timescale 1ns/1ps
`default_nettype none
module hsb_commutation_test;
  import hsb_pkg::*;
  localparam int PER = 400;
  logic core_clk, reset, hallBad, overCurrent, fcc;
  logic [2:0] sector, hallIn, hallEvent, evSeen;
  logic [15:0] busVoltage, currentRef;
  logic [31:0] avsReaddata, q, t0;
  logic avsWaitrequest, loopTrig, faultFlag;
  hsb_avs_req_t avsReq;
  hsb_bridge_t bridge;
  int failures = 0, tests_run = 0, cycles = 0, n;
  // Register rows: address then expected reset value
  logic [7:0] rowA [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] rowV [6] = '{32'h0, 32'h0, 32'h0FA0, 32'hFFFF, 32'h0, 32'h0};
  hsb_commutation #(.PWM_PERIOD_CYC(PER)) DUT (.core_clk(core_clk), .reset(reset), .avsReq(avsReq),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .hallIn(hallIn),
    .fastCurrentComparator(fcc), .busVoltage(busVoltage), .bridge(bridge), .hallEvent(hallEvent),
    .loopTrig(loopTrig), .currentRef(currentRef), .faultFlag(faultFlag));
  hsb_motor_model PART (.core_clk(core_clk), .sector(sector), .hallBad(hallBad),
    .overCurrent(overCurrent), .bridge(bridge), .hallIn(hallIn), .fastCurrentComparator(fcc));
  // ************
  // Clock, timeout, shoot-through watch
  // ************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (!reset && (bridge.hi & bridge.lo) !== 3'h0) begin
      failures++;
      $display("[FAIL] shoot-through exp 0 got %b", bridge.hi & bridge.lo);
    end
    if (cycles == 60000) begin
      failures++;
      results();
    end
  end
  // Compare of one value
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsReq <= '{read: !wr, write: wr, address: a, writedata: d};
    // Ends when waitrequest is seen low; only the bench timeout ends a hung wait
    do begin
      @(posedge core_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Wait long enough for a boundary plus dead time
  task automatic settle();
    repeat (3 * PER) @(posedge core_clk);
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    reset = 1'b1;
    avsReq = '0;
    sector = 3'h0;
    hallBad = 1'b0;
    overCurrent = 1'b0;
    busVoltage = 16'h1000;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    check("currentRef", 32'h0FA0, {16'h0, currentRef});
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rowA[i], 32'h0);
      check("reg reset", rowV[i], q);
    end
    $display("reset values done");
    bus(1'b0, 8'h08, 32'h0);
    check("hall fault", 32'h1, {31'h0, q[5]});
    bus(1'b1, 8'h08, 32'hF0);
    bus(1'b1, 8'h04, PER);
    bus(1'b1, 8'h00, 32'h1);
    settle();
    check("ccw 100", 32'h0C, {26'h0, bridge});
    bus(1'b1, 8'h00, 32'h3);
    settle();
    check("cw 100", 32'h21, {26'h0, bridge});
    // Hall edges of both polarities on phase B
    for (int k = 0; k < 2; k++) begin
      bus(1'b0, 8'h0C, 32'h0);
      t0 = q;
      sector <= k ? 3'h0 : 3'h1;
      evSeen = 3'h0;
      n = 0;
      repeat (8) begin
        @(posedge core_clk);
        evSeen = evSeen | hallEvent;
        n = n + (hallEvent[1] === 1'b1);
      end
      check("event lines", 32'h2, {29'h0, evSeen});
      check("event count", 32'h1, n);
      bus(1'b0, 8'h0C, 32'h0);
      check("time moved", 32'h1, {31'h0, q !== t0});
      settle();
      check("cw vector", k ? 32'h21 : 32'h22, {26'h0, bridge});
    end
    $display("commutation done");
    bus(1'b0, 8'h1C, 32'h0);
    t0 = q;
    bus(1'b0, 8'h1C, 32'h0);
    check("time rate", 32'h1, {31'h0, (q - t0) inside {[1 : 3]}});
    // Sensor fault then bus-current fault, each cleared again
    for (int k = 0; k < 2; k++) begin
      if (k) overCurrent <= 1'b1;
      else hallBad <= 1'b1;
      repeat (6) @(posedge core_clk);
      check("off", 32'h0, {26'h0, bridge});
      check("faultFlag", 32'h1, {31'h0, faultFlag});
      bus(1'b0, 8'h08, 32'h0);
      check("sticky", 32'h1, {31'h0, k ? q[4] : q[5]});
      hallBad <= 1'b0;
      overCurrent <= 1'b0;
      repeat (4) @(posedge core_clk);
      bus(1'b1, 8'h08, 32'hF0);
      settle();
      check("re-enable", 32'h21, {26'h0, bridge});
    end
    // Bus voltage above its limit trips at the next loop trigger
    bus(1'b1, 8'h14, 32'h0800);
    repeat (20 * PER + 4) @(posedge core_clk);
    bus(1'b0, 8'h08, 32'h0);
    check("ov sticky", 32'h1, {31'h0, q[6]});
    check("ov off", 32'h0, {26'h0, bridge});
    bus(1'b1, 8'h14, 32'hFFFF);
    bus(1'b1, 8'h08, 32'hF0);
    // High-side chop, low side on: phase A low leg never chopped
    bus(1'b1, 8'h04, PER / 2);
    bus(1'b1, 8'h00, 32'h7);
    settle();
    n = 0;
    t0 = 32'h0;
    repeat (PER) begin
      @(posedge core_clk);
      n = n + (bridge.lo[0] === 1'b1);
      t0 = t0 + (bridge.hi[2] === 1'b1);
    end
    check("low leg steady", PER, n);
    check("high leg chopped", 32'h1, {31'h0, t0 < PER});
    $display("voltage and chop done");
    n = 0;
    while (loopTrig !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (loopTrig !== 1'b1 && n < 9000);
    check("loop period", 20 * PER, n);
    $display("faults and loop done");
    results();
  end
endmodule // hsb_commutation_test
`default_nettype wire
